// ===== rcg_far_end.sv
// Purpose: far-side model of user clocks and pin wiring
// Assumes: pins have no pull, so an undriven pin toggles
// Notes: user clock period 32 cycles, demodulation 4 cycles late
`default_nettype none
module rcg_far_end (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic drive_on,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    output logic [2:0] pin_in
);
    logic [4:0] cnt, next_cnt;
    logic [3:0] dly, next_dly;
    logic [2:0] far;
    always_comb begin
        next_cnt = cnt + 5'h01;
        next_dly = {dly[2:0], cnt[4]};
        // 45 degree lag plus xor blocking signal
        far = drive_on ? {dly[3], cnt[4], dly[3] ^ cnt[4]} : {3{cnt[0]}};
        // only the shared pins are modelled; biopotential is taken elsewhere
        pin_in = (pin_oe & pin_out) | (~pin_oe & far);
    end
    // timed from the bench clock, not an internal oscillator
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt <= 5'h00;
            dly <= 4'h0;
        end else begin
            cnt <= next_cnt;
            dly <= next_dly;
        end
    end
endmodule
`default_nettype wire

// ===== rcg_gen_if.sv
// Purpose: link between register side and clock generator
// Assumes: one clock domain
// Notes:   ctrl drives settings, gen returns clocks
`default_nettype none
interface rcg_gen_if;
    logic run;
    logic [2:0] freq_sel;
    logic [2:0] phase_sel;
    logic mod_clk;
    logic demod_clk;

    modport ctrl (output run, output freq_sel, output phase_sel,
                  input mod_clk, input demod_clk);
    modport gen (input run, input freq_sel, input phase_sel,
                 output mod_clk, output demod_clk);
endinterface
`default_nettype wire

// ===== rcg_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the
//          respiration modulation clock generator
// Assumes: 40 MHz system clock, 32-bit Avalon-MM register port
// Notes:   definitions only
`ifndef RCG_MAP_SVH
`define RCG_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RCG_ADDR_CTRL 4'h0
`define RCG_ADDR_FREQ 4'h4
`define RCG_ADDR_GPIO 4'h8
`define RCG_ADDR_STAT 4'hC

// ----------------------------------------
// field positions
// ----------------------------------------
`define RCG_CTRL_MODE 1:0
`define RCG_CTRL_PHASE 4:2
`define RCG_CTRL_MOD_EN 5
`define RCG_CTRL_DEMOD_EN 6
`define RCG_FREQ_SEL 2:0
`define RCG_GPIO_OE 2:0
`define RCG_GPIO_OUT 6:4
`define RCG_STAT_PINS 2:0
`define RCG_STAT_MOD 3
`define RCG_STAT_DEMOD 4
`define RCG_STAT_BLOCK 5
`define RCG_STAT_MODE 7:6

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RCG_CTRL_RST 7'h00
`define RCG_FREQ_RST 3'h0
`define RCG_GPIO_RST 6'h00
`define RCG_FREQ_64K 3'h0
`define RCG_FREQ_32K 3'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define RCG_SYS_CLK_HZ 64'd40000000
`define RCG_MOD_HZ 64'd64000
`define RCG_PHASE_STEPS 64'd16
`define RCG_NCO_SPAN 64'd65536
`define RCG_NCO_INC \
    16'((`RCG_MOD_HZ * `RCG_PHASE_STEPS * `RCG_NCO_SPAN) / `RCG_SYS_CLK_HZ)

`endif

// ===== rcg_phase_gen.sv
// Purpose: modulation clock and phase-delayed demodulation clock
// Assumes: sys_clk at 40 MHz
// Notes:   16 phase steps per period, 22.5 degrees each
`include "rcg_map.svh"
`default_nettype none
module rcg_phase_gen (
    input wire logic sys_clk,
    input wire logic reset,
    rcg_gen_if.gen gif
);
    logic [15:0] nco;
    logic [15:0] next_nco;
    logic [6:0] presc;
    logic [6:0] next_presc;
    logic [3:0] ph;
    logic [3:0] next_ph;
    logic mod_q;
    logic demod_q;
    logic next_mod;
    logic next_demod;
    logic [16:0] sum;
    logic [6:0] mask;
    logic step;
    logic [3:0] offs;
    logic [3:0] ph_d;
    logic primed;
    logic next_primed;

    // ----------------------------------------
    // rate and phase stepping
    // ----------------------------------------
    always_comb begin
        sum = {1'b0, nco} + {1'b0, `RCG_NCO_INC};
        mask = 7'((8'h01 << gif.freq_sel) - 8'h01);
        step = sum[16] && ((presc & mask) == mask);
        offs = (gif.phase_sel == 3'h0) ? 4'h1 : {1'b0, gif.phase_sel};
        next_nco = nco;
        next_presc = presc;
        next_ph = ph;
        if (!gif.run) begin
            next_nco = 16'h0000;
            next_presc = 7'h00;
            next_ph = 4'h0;
        end else begin
            next_nco = sum[15:0];
            if (sum[16]) begin
                next_presc = presc + 7'h01;
            end
            if (step) begin
                next_ph = ph + 4'h1;
            end
        end
        ph_d = next_ph - offs;
        next_mod = gif.run && next_ph[3];
        // demodulation waits for the first modulation high after start
        next_primed = gif.run && (primed || mod_q);
        next_demod = gif.run && ph_d[3] && (primed || mod_q);
        if (!gif.run) begin
            next_demod = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            nco <= 16'h0000;
            presc <= 7'h00;
            ph <= 4'h0;
            mod_q <= 1'b0;
            demod_q <= 1'b0;
            primed <= 1'b0;
        end else begin
            nco <= next_nco;
            presc <= next_presc;
            ph <= next_ph;
            mod_q <= next_mod;
            demod_q <= next_demod;
            primed <= next_primed;
        end
    end

    assign gif.mod_clk = mod_q;
    assign gif.demod_clk = demod_q;
endmodule
`default_nettype wire

// ===== rcg_pkg.sv
// Purpose: types of the respiration modulation clock generator
// Assumes: nothing
// Notes:   constants live in rcg_map.svh
`default_nettype none
package rcg_pkg;
    typedef enum logic [1:0] {
        RCG_MODE_OFF = 2'h0,
        RCG_MODE_EXT = 2'h1,
        RCG_MODE_INT = 2'h2,
        RCG_MODE_USER = 2'h3
    } rcg_mode_t;

    typedef enum logic [1:0] {
        RCG_BUS_IDLE = 2'b01,
        RCG_BUS_ACK = 2'b10
    } rcg_bus_state_t;
endpackage
`default_nettype wire

// ===== rcg_top.sv
// Purpose: respiration modulation clock generation and pin routing
// Assumes: 40 MHz sys_clk, asynchronous active-high reset, Avalon-MM slave
// Notes:   pin vectors index 0 = pin two, 1 = pin three, 2 = pin four
`include "rcg_map.svh"
`default_nettype none
module rcg_top (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [2:0] gp_pin_in,
    output logic [2:0] gp_pin_out,
    output logic [2:0] gp_pin_oe,
    output logic mod_out_pos,
    output logic mod_out_neg,
    output logic control_reg_a_mod_clk,
    output logic control_reg_a_demod_clk,
    output logic control_reg_a_block
);
    rcg_gen_if gif ();

    // ----------------------------------------
    // state
    // ----------------------------------------
    rcg_pkg::rcg_bus_state_t bus_state;
    rcg_pkg::rcg_bus_state_t next_bus_state;
    logic [1:0] control_reg_a_mode_select;
    logic [1:0] next_control_reg_a_mode_select;
    logic [2:0] demod_phase_select;
    logic [2:0] next_demod_phase_select;
    logic mod_block_on;
    logic next_mod_block_on;
    logic demod_block_on;
    logic next_demod_block_on;
    logic [2:0] mod_freq_select;
    logic [2:0] next_mod_freq_select;
    logic [2:0] gp_oe_reg;
    logic [2:0] next_gp_oe_reg;
    logic [2:0] gp_out_reg;
    logic [2:0] next_gp_out_reg;
    logic next_waitrequest;
    logic [31:0] next_readdata;
    wire logic [2:0] pin_sync;
    logic [31:0] read_word;
    logic [2:0] next_pin_out;
    logic [2:0] next_pin_oe;
    logic next_mod_pos;
    logic next_mod_neg;
    logic next_mod_clk;
    logic next_demod_clk;
    logic next_block;
    rcg_pkg::rcg_mode_t mode;
    logic xor_ok;
    logic do_write;

    // ----------------------------------------
    // generator
    // ----------------------------------------
    always_comb begin
        mode = rcg_pkg::rcg_mode_t'(control_reg_a_mode_select);
        gif.run = (mode == rcg_pkg::RCG_MODE_EXT) || (mode == rcg_pkg::RCG_MODE_INT);
        gif.freq_sel = mod_freq_select;
        gif.phase_sel = demod_phase_select;
    end

    rcg_phase_gen u_gen (
        .sys_clk(sys_clk),
        .reset(reset),
        .gif(gif)
    );

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    always_comb begin
        read_word = 32'h0000_0000;
        case (avs_address)
            `RCG_ADDR_CTRL: begin
                read_word[`RCG_CTRL_MODE] = control_reg_a_mode_select;
                read_word[`RCG_CTRL_PHASE] = demod_phase_select;
                read_word[`RCG_CTRL_MOD_EN] = mod_block_on;
                read_word[`RCG_CTRL_DEMOD_EN] = demod_block_on;
            end
            `RCG_ADDR_FREQ: begin
                read_word[`RCG_FREQ_SEL] = mod_freq_select;
            end
            `RCG_ADDR_GPIO: begin
                read_word[`RCG_GPIO_OE] = gp_oe_reg;
                read_word[`RCG_GPIO_OUT] = gp_out_reg;
            end
            `RCG_ADDR_STAT: begin
                read_word[`RCG_STAT_PINS] = pin_sync;
                read_word[`RCG_STAT_MOD] = control_reg_a_mod_clk;
                read_word[`RCG_STAT_DEMOD] = control_reg_a_demod_clk;
                read_word[`RCG_STAT_BLOCK] = control_reg_a_block;
                read_word[`RCG_STAT_MODE] = control_reg_a_mode_select;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    always_comb begin
        do_write = avs_write && (bus_state == rcg_pkg::RCG_BUS_ACK) && avs_byteenable[0];
        next_bus_state = bus_state;
        next_waitrequest = 1'b1;
        next_readdata = avs_readdata;
        next_control_reg_a_mode_select = control_reg_a_mode_select;
        next_demod_phase_select = demod_phase_select;
        next_mod_block_on = mod_block_on;
        next_demod_block_on = demod_block_on;
        next_mod_freq_select = mod_freq_select;
        next_gp_oe_reg = gp_oe_reg;
        next_gp_out_reg = gp_out_reg;
        case (bus_state)
            rcg_pkg::RCG_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    next_bus_state = rcg_pkg::RCG_BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata = 32'h0000_0000;
                    if (avs_read) begin
                        next_readdata = read_word;
                    end
                end
            end
            rcg_pkg::RCG_BUS_ACK: begin
                next_bus_state = rcg_pkg::RCG_BUS_IDLE;
                if (do_write) begin
                    case (avs_address)
                        `RCG_ADDR_CTRL: begin
                            next_control_reg_a_mode_select = avs_writedata[`RCG_CTRL_MODE];
                            next_demod_phase_select = avs_writedata[`RCG_CTRL_PHASE];
                            next_mod_block_on = avs_writedata[`RCG_CTRL_MOD_EN];
                            next_demod_block_on = avs_writedata[`RCG_CTRL_DEMOD_EN];
                        end
                        `RCG_ADDR_FREQ: begin
                            next_mod_freq_select = avs_writedata[`RCG_FREQ_SEL];
                        end
                        `RCG_ADDR_GPIO: begin
                            // stored in every mode, applied only when the pins are free
                            next_gp_oe_reg = avs_writedata[`RCG_GPIO_OE];
                            next_gp_out_reg = avs_writedata[`RCG_GPIO_OUT];
                        end
                        default: begin
                            next_gp_oe_reg = gp_oe_reg;
                        end
                    endcase
                end
            end
            default: begin
                next_bus_state = rcg_pkg::RCG_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bus_state <= rcg_pkg::RCG_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            control_reg_a_mode_select <= 2'(`RCG_CTRL_RST);
            demod_phase_select <= 3'h0;
            mod_block_on <= 1'b0;
            demod_block_on <= 1'b0;
            mod_freq_select <= `RCG_FREQ_RST;
            gp_oe_reg <= 3'h0;
            gp_out_reg <= 3'h0;
        end else begin
            bus_state <= next_bus_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
            control_reg_a_mode_select <= next_control_reg_a_mode_select;
            demod_phase_select <= next_demod_phase_select;
            mod_block_on <= next_mod_block_on;
            demod_block_on <= next_demod_block_on;
            mod_freq_select <= next_mod_freq_select;
            gp_oe_reg <= next_gp_oe_reg;
            gp_out_reg <= next_gp_out_reg;
        end
    end

    // ----------------------------------------
    // pin input synchroniser
    // ----------------------------------------
    genvar pin_idx;
    generate
        for (pin_idx = 0; pin_idx < 3; pin_idx = pin_idx + 1) begin : g_pin_sync
            logic meta_q;
            logic sync_q;
            logic next_meta;
            logic next_sync;
            always_comb begin
                next_meta = gp_pin_in[pin_idx];
                next_sync = meta_q;
            end
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= next_meta;
                    sync_q <= next_sync;
                end
            end
            assign pin_sync[pin_idx] = sync_q;
        end
    endgenerate

    // ----------------------------------------
    // pin and clock routing
    // ----------------------------------------
    always_comb begin
        xor_ok = (mod_freq_select == `RCG_FREQ_64K) || (mod_freq_select == `RCG_FREQ_32K);
    end

    always_comb begin
        next_pin_out = gp_out_reg;
        next_pin_oe = gp_oe_reg;
        next_mod_pos = 1'b0;
        next_mod_neg = 1'b0;
        next_mod_clk = 1'b0;
        next_demod_clk = 1'b0;
        next_block = 1'b0;
        case (mode)
            rcg_pkg::RCG_MODE_EXT: begin
                next_pin_oe = 3'h7;
                next_pin_out[1] = gif.mod_clk;
                next_pin_out[2] = gif.demod_clk;
                next_pin_out[0] = xor_ok && (gif.mod_clk ^ gif.demod_clk);
                next_mod_clk = gif.mod_clk;
                next_demod_clk = gif.demod_clk;
                next_block = next_pin_out[0];
            end
            rcg_pkg::RCG_MODE_INT: begin
                // pins keep software settings here
                next_mod_pos = mod_block_on && gif.mod_clk;
                next_mod_neg = mod_block_on && !gif.mod_clk;
                next_mod_clk = mod_block_on && gif.mod_clk;
                next_demod_clk = demod_block_on && gif.demod_clk;
                next_block = next_mod_clk ^ next_demod_clk;
            end
            rcg_pkg::RCG_MODE_USER: begin
                next_pin_oe = 3'h0;
                next_pin_out = 3'h0;
                next_mod_clk = pin_sync[1];
                next_demod_clk = pin_sync[2];
                next_block = pin_sync[0];
            end
            default: begin
                next_pin_out = gp_out_reg;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            gp_pin_out <= 3'h0;
            gp_pin_oe <= 3'h0;
            mod_out_pos <= 1'b0;
            mod_out_neg <= 1'b0;
            control_reg_a_mod_clk <= 1'b0;
            control_reg_a_demod_clk <= 1'b0;
            control_reg_a_block <= 1'b0;
        end else begin
            gp_pin_out <= next_pin_out;
            gp_pin_oe <= next_pin_oe;
            mod_out_pos <= next_mod_pos;
            mod_out_neg <= next_mod_neg;
            control_reg_a_mod_clk <= next_mod_clk;
            control_reg_a_demod_clk <= next_demod_clk;
            control_reg_a_block <= next_block;
        end
    end
endmodule
`default_nettype wire

// ===== rcg_top_checker.sv
// Purpose: port checks of rcg_top
// Assumes: mode and fields shadowed from landed register writes
// Notes: pin checks start 8 cycles after the last write
`include "rcg_map.svh"
`default_nettype none
module rcg_top_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [2:0] gp_pin_in,
    input wire logic [2:0] gp_pin_out,
    input wire logic [2:0] gp_pin_oe,
    input wire logic mod_out_pos,
    input wire logic mod_out_neg,
    input wire logic control_reg_a_mod_clk,
    input wire logic control_reg_a_demod_clk,
    input wire logic control_reg_a_block
);
    logic [6:0] c, next_c, g, next_g;
    logic [2:0] f, next_f;
    logic [3:0] q, next_q;
    logic wr, ok;
    logic [1:0] m;
    always_comb begin
        wr = avs_write && !avs_waitrequest && avs_byteenable[0];
        next_c = (wr && avs_address == `RCG_ADDR_CTRL) ? avs_writedata[6:0] : c;
        next_f = (wr && avs_address == `RCG_ADDR_FREQ) ? avs_writedata[2:0] : f;
        next_g = (wr && avs_address == `RCG_ADDR_GPIO) ? avs_writedata[6:0] : g;
        next_q = wr ? 4'h0 : q + {3'h0, q != 4'hf};
        m = c[`RCG_CTRL_MODE];
        ok = q[3];
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            c <= 7'h00;
            f <= 3'h0;
            g <= 7'h00;
            q <= 4'h0;
        end else begin
            c <= next_c;
            f <= next_f;
            g <= next_g;
            q <= next_q;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ext_oe_a: assert property (ok && m == 2'h1 |-> gp_pin_oe == 3'h7)
        else $error("pins not outputs in external mode");
    xor_pin_a: assert property (ok && m == 2'h1 && f < 3'h2
        |-> gp_pin_out[0] == (gp_pin_out[1] ^ gp_pin_out[2])) else $error("pin two not xor");
    xor_off_a: assert property (ok && m == 2'h1 && f > 3'h1 |-> !gp_pin_out[0])
        else $error("xor present on other codes");
    gpio_free_a: assert property (ok && !m[0]
        |-> gp_pin_oe == g[2:0] && gp_pin_out == g[6:4]) else $error("pins not general");
    user_in_a: assert property (ok && m == 2'h3 |-> gp_pin_oe == 3'h0)
        else $error("pins driven in user mode");
    user_clk_a: assert property (ok && m == 2'h3
        |-> {control_reg_a_demod_clk, control_reg_a_mod_clk, control_reg_a_block} == $past(gp_pin_in, 3))
        else $error("user clocks not taken");
    mod_gate_a: assert property (ok && m == 2'h2 && !c[5]
        |-> !mod_out_pos && !mod_out_neg && !control_reg_a_mod_clk) else $error("modulation ran");
    mod_pair_a: assert property (ok && m == 2'h2 && c[5] |-> mod_out_neg == !mod_out_pos)
        else $error("modulation terminals not complementary");
    demod_gate_a: assert property (ok && m == 2'h2 && !c[6] |-> !control_reg_a_demod_clk)
        else $error("demodulation ran");
    off_idle_a: assert property (ok && m == 2'h0
        |-> !control_reg_a_mod_clk && !control_reg_a_demod_clk && !mod_out_pos) else $error("clocks in off");
    bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");
    cover property (ok && m == 2'h1 && f > 3'h1 && gp_pin_out[1]);
    cover property (ok && m == 2'h3 && control_reg_a_block);
    cover property (ok && m == 2'h2 && c[6] && control_reg_a_demod_clk);
endmodule
`default_nettype wire

// ===== rcg_top_test.sv
// Purpose: self-checking bench of rcg_top
// Assumes: rcg_far_end supplies user clocks in mode 11
// Notes: clock periods measured in sys_clk cycles
`include "rcg_map.svh"
`default_nettype none
module rcg_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, reset, avs_read, avs_write, avs_waitrequest, far_on;
    logic mod_out_pos, mod_out_neg, control_reg_a_mod_clk, control_reg_a_demod_clk, control_reg_a_block;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdata;
    logic [2:0] gp_pin_in, gp_pin_out, gp_pin_oe;
    logic [5:0] sigs;
    int fail_count, tests_run, cycles, n, c;
    assign sigs = {mod_out_pos, control_reg_a_demod_clk, control_reg_a_mod_clk, gp_pin_out};
    rcg_top DUT (.sys_clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .gp_pin_in, .gp_pin_out,
        .gp_pin_oe, .mod_out_pos, .mod_out_neg, .control_reg_a_mod_clk, .control_reg_a_demod_clk, .control_reg_a_block);
    rcg_far_end far (.sys_clk(sys_clk), .reset(reset), .drive_on(far_on),
        .pin_out(gp_pin_out), .pin_oe(gp_pin_oe), .pin_in(gp_pin_in));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] v);
        tests_run++;
        if (v !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", s, e, v);
        end
    endtask
    task chk_in(input string s, input int lo, input int hi, input int v);
        tests_run++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("ERROR %s exp %0d..%0d got %0d", s, lo, hi, v);
        end
    endtask
    task bus(input logic w, input logic [3:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        avs_address <= ad;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // cycles from a rise of sigs[a] to the next rise of sigs[b]
    task gap(input int a, input int b);
        logic p;
        int k;
        for (k = 0; k < 20000; k++) begin
            p = sigs[a];
            @(posedge sys_clk);
            #1;
            if (sigs[a] && !p) break;
        end
        for (n = 1; n < 20000; n++) begin
            p = sigs[b];
            @(posedge sys_clk);
            #1;
            if (sigs[b] && !p) break;
        end
    endtask
    task t_regs;
        bus(0, `RCG_ADDR_CTRL, 8'h00);
        chk("ctrl", 32'h0000_0000, rdata);
        bus(0, 4'h2, 8'h00);
        chk("hole", 32'h0000_0000, rdata);
        avs_byteenable <= 4'he;
        bus(1, `RCG_ADDR_GPIO, 8'h35);
        avs_byteenable <= 4'hf;
        bus(0, `RCG_ADDR_GPIO, 8'h00);
        chk("lane", 32'h0000_0000, rdata);
        bus(1, `RCG_ADDR_GPIO, 8'h35);
        bus(0, `RCG_ADDR_GPIO, 8'h00);
        chk("gpio", 32'h0000_0035, rdata);
        chk("gp oe", 3'h5, gp_pin_oe);
    endtask
    task t_ext;
        bus(1, `RCG_ADDR_CTRL, 8'h1d);
        repeat (4) @(posedge sys_clk);
        chk("ext oe", 3'h7, gp_pin_oe);
        chk("ext pos", 1'b0, mod_out_pos);
        gap(1, 1);
        chk_in("period", 623, 627, n);
        gap(1, 2);
        chk_in("phase 7", 271, 276, n);
        bus(1, `RCG_ADDR_CTRL, 8'h01);
        bus(1, `RCG_ADDR_GPIO, 8'h00);
        gap(1, 2);
        chk_in("phase 0", 37, 41, n);
        chk("ext held", 3'h7, gp_pin_oe);
        bus(0, `RCG_ADDR_STAT, 8'h00);
        chk("mode", 2'h1, rdata[7:6]);
        for (c = 1; c < 4; c++) begin
            bus(1, `RCG_ADDR_FREQ, c[7:0]);
            gap(1, 1);
            chk_in("freq", (625 << c) - 2, (626 << c) + 2, n);
            chk("xor", c < 2 ? gp_pin_out[1] ^ gp_pin_out[2] : 1'b0, gp_pin_out[0]);
        end
        bus(1, `RCG_ADDR_FREQ, 8'h00);
    endtask
    task t_int;
        bus(1, `RCG_ADDR_CTRL, 8'h2e);
        repeat (4) @(posedge sys_clk);
        chk("int oe", 3'h0, gp_pin_oe);
        gap(5, 5);
        chk_in("term", 623, 627, n);
        chk("demod off", 1'b0, control_reg_a_demod_clk);
        bus(1, `RCG_ADDR_CTRL, 8'h6e);
        gap(3, 4);
        chk_in("int phase", 115, 120, n);
        bus(1, `RCG_ADDR_CTRL, 8'h4e);
        gap(4, 4);
        chk_in("demod", 623, 627, n);
        chk("mod off", 1'b0, mod_out_pos);
    endtask
    task t_user;
        far_on <= 1'b1;
        bus(1, `RCG_ADDR_CTRL, 8'h03);
        bus(1, `RCG_ADDR_GPIO, 8'h52);
        repeat (8) @(posedge sys_clk);
        chk("user oe", 3'h0, gp_pin_oe);
        gap(3, 4);
        chk_in("user lag", 4, 4, n);
        gap(3, 3);
        chk_in("user per", 32, 32, n);
        far_on <= 1'b0;
        bus(1, `RCG_ADDR_CTRL, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk("off oe", 3'h2, gp_pin_oe);
        chk("off out", 3'h5, gp_pin_out);
        chk("off clk", 1'b0, control_reg_a_mod_clk);
    endtask
    initial begin
        reset = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        far_on = 1'b0;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs;
        t_ext;
        t_int;
        t_user;
        report_and_stop;
    end
endmodule
bind rcg_top rcg_top_checker chk_i (.sys_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_waitrequest, .gp_pin_in, .gp_pin_out, .gp_pin_oe,
    .mod_out_pos, .mod_out_neg, .control_reg_a_mod_clk, .control_reg_a_demod_clk, .control_reg_a_block);
`default_nettype wire
